// ### src/mtmr_top.v
// Purpose: 8-bit modulo timer with source select, prescaler and overflow irq
// Assumes: single 200 MHz clock MCLK, async active-low RSTN, AXI4-Lite slave
// Notes: fixed-rate clock and count pin are sampled on MCLK, never used as
//        clocks; unmapped addresses answer SLVERR
//        prescaler phase is kept across halts and source or ratio changes;
//        the irq pin lags the flag by one cycle
`timescale 1ns/1ps
`include "mtmr_defines.vh"

module mtmr_top (
    input wire MCLK,
    input wire RSTN,
    input wire FIXED_RATE_CLOCK,
    input wire EXTERNAL_COUNT_PIN,
    output reg IRQ,
    input wire [7:0] S_AXI_AWADDR,
    input wire S_AXI_AWVALID,
    output reg S_AXI_AWREADY,
    input wire [31:0] S_AXI_WDATA,
    input wire [3:0] S_AXI_WSTRB,
    input wire S_AXI_WVALID,
    output reg S_AXI_WREADY,
    output reg [1:0] S_AXI_BRESP,
    output reg S_AXI_BVALID,
    input wire S_AXI_BREADY,
    input wire [7:0] S_AXI_ARADDR,
    input wire S_AXI_ARVALID,
    output reg S_AXI_ARREADY,
    output reg [31:0] S_AXI_RDATA,
    output reg [1:0] S_AXI_RRESP,
    output reg S_AXI_RVALID,
    input wire S_AXI_RREADY
);

    // ========================================================
    // helpers
    // ========================================================
    // true when a byte address maps to a register; both bus paths use it,
    // so unmapped reads and writes answer alike
    function is_mapped;
        input [7:0] a;
        begin
            is_mapped = (a == `MTMR_OFF_STATUS) || (a == `MTMR_OFF_CLKCFG) ||
                (a == `MTMR_OFF_COUNT) || (a == `MTMR_OFF_LIMIT);
        end
    endfunction

    // ========================================================
    // registers
    // ========================================================
    // register map, one 32-bit word each, data in bits 7:0:
    //   0x00 status/control: b7 flag, b6 irq enable, b5 clear, b4 halt
    //   0x04 clock config: b5:4 source, b3:0 prescale code
    //   0x08 count, read-only; writes answer okay and change nothing
    //   0x0c wrap limit; any write with the lane 0 strobe restarts the count from zero
    // other addresses read zero and answer slverr
    // software-visible fields
    reg [1:0] clock_source_select_r;
    reg [3:0] prescale_select_r;
    reg [7:0] timer_count_value_r;
    reg [7:0] wrap_limit_value_r;
    reg overflow_flag_r;
    reg overflow_irq_enable_r;
    reg counter_halt_bit_r;
    // internal state
    reg clr_armed_r;
    reg [7:0] presc_r;

    // ========================================================
    // pin synchronisers
    // ========================================================
    // neither sampled input is ever used as a clock: one clock domain
    // costs three cycles of latency per edge and caps the input rate, but
    // keeps every crossing hazard out of the counter logic
    // three stages; the first is read only by the second
    reg [2:0] fix_sync_r;
    reg [2:0] pin_sync_r;
    reg fix_lvl_r;
    reg pin_lvl_r;

    // a change counts once stages two and three agree
    always @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            fix_sync_r <= 3'h0;
            pin_sync_r <= 3'h0;
            fix_lvl_r <= 1'b0;
            pin_lvl_r <= 1'b0;
        end else begin
            fix_sync_r <= {fix_sync_r[1:0], FIXED_RATE_CLOCK};
            pin_sync_r <= {pin_sync_r[1:0], EXTERNAL_COUNT_PIN};
            if (fix_sync_r[1] == fix_sync_r[2]) begin
                fix_lvl_r <= fix_sync_r[2];
            end
            if (pin_sync_r[1] == pin_sync_r[2]) begin
                pin_lvl_r <= pin_sync_r[2];
            end
        end
    end

    // edges of the filtered levels; pin must stay under a quarter of MCLK
    // each edge is a single-cycle pulse, seen three to four cycles late
    wire fix_rise = (fix_sync_r[1] == fix_sync_r[2]) &&
        fix_sync_r[2] && !fix_lvl_r;
    wire pin_rise = (pin_sync_r[1] == pin_sync_r[2]) &&
        pin_sync_r[2] && !pin_lvl_r;
    wire pin_fall = (pin_sync_r[1] == pin_sync_r[2]) &&
        !pin_sync_r[2] && pin_lvl_r;

    // ========================================================
    // source select and prescaler
    // ========================================================
    reg src_pulse;

    // source mux; switching never touches the count
    // 00 bus: every cycle, 01 fixed-rate rising edge, 10 pin falling edge,
    // 11 pin rising edge
    always @* begin
        case (clock_source_select_r)
            `MTMR_SRC_BUS: src_pulse = 1'b1;
            `MTMR_SRC_FIXED: src_pulse = fix_rise;
            `MTMR_SRC_FALL: src_pulse = pin_fall;
            default: src_pulse = pin_rise;
        endcase
    end

    // divider runs only while counting so a halt freezes the phase too
    // it wraps by itself after 256 source pulses, the largest ratio
    always @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            presc_r <= 8'h00;
        end else if (src_pulse && !counter_halt_bit_r) begin
            presc_r <= presc_r + 8'h01;
        end
    end

    // tick when all bits below the selected tap are ones: code n gives
    // one tick per 2^n source pulses, codes above eight are clamped
    // the phase survives a ratio or source change, so the first period
    // after a change may be short; exact timing must allow for that
    wire [3:0] pre_eff = (prescale_select_r > `MTMR_PRE_MAX) ?
        `MTMR_PRE_MAX : prescale_select_r;
    wire [8:0] pre_mask = (9'h001 << pre_eff) - 9'h001;
    wire tick = src_pulse && !counter_halt_bit_r &&
        ((presc_r & pre_mask[7:0]) == pre_mask[7:0]);

    // ========================================================
    // AXI4-Lite write path
    // ========================================================
    reg [7:0] aw_addr_r;
    reg aw_held_r;
    reg [31:0] w_data_r;
    reg [3:0] w_strb_r;
    reg w_held_r;

    // a held pair acts once the previous response has been accepted
    wire wr_go = aw_held_r && w_held_r && !S_AXI_BVALID;
    wire wr_lane0 = wr_go && w_strb_r[0];
    wire wr_sc = wr_lane0 && (aw_addr_r == `MTMR_OFF_STATUS);
    wire wr_ck = wr_lane0 && (aw_addr_r == `MTMR_OFF_CLKCFG);
    wire wr_lim = wr_lane0 && (aw_addr_r == `MTMR_OFF_LIMIT);
    wire wr_clr = wr_sc && w_data_r[`MTMR_SC_CLR];

    // with address and data offered together: readies pulse at edge 1,
    // both are taken at edge 2, the register acts and the response rises
    // at edge 3; a second beat waits until the held pair has been used
    // lane 0 strobe gates the effect, the other lanes are ignored
    // address and data taken in either order, response after both
    always @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            aw_addr_r <= 8'h00;
            aw_held_r <= 1'b0;
            w_data_r <= 32'h0;
            w_strb_r <= 4'h0;
            w_held_r <= 1'b0;
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY <= 1'b0;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= `MTMR_RESP_OKAY;
        end else begin
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY <= 1'b0;
            if (!aw_held_r && S_AXI_AWVALID && !S_AXI_AWREADY) begin
                S_AXI_AWREADY <= 1'b1;
            end
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_addr_r <= S_AXI_AWADDR;
                aw_held_r <= 1'b1;
            end
            if (!w_held_r && S_AXI_WVALID && !S_AXI_WREADY) begin
                S_AXI_WREADY <= 1'b1;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_data_r <= S_AXI_WDATA;
                w_strb_r <= S_AXI_WSTRB;
                w_held_r <= 1'b1;
            end
            if (wr_go) begin
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP <= is_mapped(aw_addr_r) ?
                    `MTMR_RESP_OKAY : `MTMR_RESP_SLVERR;
            end else if (S_AXI_BVALID && S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
            end
        end
    end

    // ========================================================
    // AXI4-Lite read path
    // ========================================================
    // address taken at the handshake edge; a status read may arm the clear
    wire rd_take = S_AXI_ARVALID && S_AXI_ARREADY;
    wire rd_sc = rd_take && (S_AXI_ARADDR == `MTMR_OFF_STATUS);
    reg [31:0] rd_mux;

    // clear bit and unused bits read as zero
    always @* begin
        rd_mux = 32'h0;
        if (S_AXI_ARADDR == `MTMR_OFF_STATUS) begin
            rd_mux[`MTMR_SC_OVF] = overflow_flag_r;
            rd_mux[`MTMR_SC_IRQEN] = overflow_irq_enable_r;
            rd_mux[`MTMR_SC_HALT] = counter_halt_bit_r;
        end else if (S_AXI_ARADDR == `MTMR_OFF_CLKCFG) begin
            rd_mux[`MTMR_CK_SRC_HI:`MTMR_CK_SRC_LO] = clock_source_select_r;
            rd_mux[`MTMR_CK_PRE_HI:`MTMR_CK_PRE_LO] = prescale_select_r;
        end else if (S_AXI_ARADDR == `MTMR_OFF_COUNT) begin
            rd_mux[7:0] = timer_count_value_r;
        end else if (S_AXI_ARADDR == `MTMR_OFF_LIMIT) begin
            rd_mux[7:0] = wrap_limit_value_r;
        end
    end

    // ready pulses at edge 1, data and response rise at edge 2; the word
    // is frozen at the taking edge and stands until it is accepted, and a
    // new address is refused while it waits
    // one read at a time; arready pulses one cycle after arvalid
    always @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= 32'h0;
            S_AXI_RRESP <= `MTMR_RESP_OKAY;
        end else begin
            S_AXI_ARREADY <= S_AXI_ARVALID && !S_AXI_ARREADY &&
                !S_AXI_RVALID;
            if (rd_take) begin
                S_AXI_RVALID <= 1'b1;
                S_AXI_RDATA <= rd_mux;
                S_AXI_RRESP <= is_mapped(S_AXI_ARADDR) ?
                    `MTMR_RESP_OKAY : `MTMR_RESP_SLVERR;
            end else if (S_AXI_RVALID && S_AXI_RREADY) begin
                S_AXI_RVALID <= 1'b0;
            end
        end
    end

    // ========================================================
    // control registers
    // ========================================================
    // halt and irq enable come from any lane 0 status write; the clear bit is a
    // strobe and is never stored
    // count register has no write path at all
    always @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            clock_source_select_r <= `MTMR_RST_SRC;
            prescale_select_r <= `MTMR_RST_PRE;
            wrap_limit_value_r <= `MTMR_RST_LIMIT;
            counter_halt_bit_r <= `MTMR_RST_HALT;
            overflow_irq_enable_r <= `MTMR_RST_IRQEN;
        end else begin
            if (wr_ck) begin
                clock_source_select_r <=
                    w_data_r[`MTMR_CK_SRC_HI:`MTMR_CK_SRC_LO];
                prescale_select_r <=
                    w_data_r[`MTMR_CK_PRE_HI:`MTMR_CK_PRE_LO];
            end
            if (wr_lim) begin
                wrap_limit_value_r <= w_data_r[7:0];
            end
            if (wr_sc) begin
                counter_halt_bit_r <= w_data_r[`MTMR_SC_HALT];
                overflow_irq_enable_r <= w_data_r[`MTMR_SC_IRQEN];
            end
        end
    end

    // ========================================================
    // counter and overflow flag
    // ========================================================
    // wrap point: programmed limit, or top of range when limit is zero;
    // a limit of 0xff and a zero limit therefore wrap at the same count
    wire [7:0] wrap_at = (wrap_limit_value_r == 8'h00) ?
        `MTMR_FREE_TOP : wrap_limit_value_r;
    wire wrap = tick && (timer_count_value_r == wrap_at);
    wire flag_wr0 = wr_sc && !w_data_r[`MTMR_SC_OVF] && clr_armed_r;

    // priorities at one edge, highest first:
    //   count: limit write or clear bit, then wrap, then tick
    //   flag: wrap, then limit write, clear bit or armed zero write
    // a wrap on the edge of a clear keeps the flag so that no overflow is
    // lost, while the count still returns to zero
    // a fresh wrap always beats any clearing source
    always @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            timer_count_value_r <= `MTMR_RST_COUNT;
            overflow_flag_r <= 1'b0;
            clr_armed_r <= 1'b0;
        end else begin
            if (wr_lim || wr_clr) begin
                timer_count_value_r <= `MTMR_RST_COUNT;
            end else if (wrap) begin
                timer_count_value_r <= 8'h00;
            end else if (tick) begin
                timer_count_value_r <= timer_count_value_r + 8'h01;
            end
            if (wrap) begin
                overflow_flag_r <= 1'b1;
            end else if (wr_lim || wr_clr || flag_wr0) begin
                overflow_flag_r <= 1'b0;
            end
            // a status read with flag set arms the clear; a wrap disarms
            // it, as do any other lane 0 status write and a flag already low
            if (wrap) begin
                clr_armed_r <= 1'b0;
            end else if (rd_sc && overflow_flag_r) begin
                clr_armed_r <= 1'b1;
            end else if (wr_sc || !overflow_flag_r) begin
                clr_armed_r <= 1'b0;
            end
        end
    end

    // ========================================================
    // interrupt output
    // ========================================================
    // registered so the pin is glitch free; the cost is one cycle of lag
    // behind the flag, and enabling with the flag set raises it at once
    always @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= overflow_flag_r && overflow_irq_enable_r;
        end
    end

endmodule

// ### src/mtmr_defines.vh
// Purpose: register map, field positions and reset values of the modulo timer
// Assumes: AXI4-Lite, 32-bit data, one aligned word per register
// Notes: offsets are byte addresses on the register bus
`ifndef MTMR_DEFINES_VH
`define MTMR_DEFINES_VH

`define MTMR_ADDR_W 8
`define MTMR_OFF_STATUS 8'h00
`define MTMR_OFF_CLKCFG 8'h04
`define MTMR_OFF_COUNT 8'h08
`define MTMR_OFF_LIMIT 8'h0c

// status_control_reg fields
`define MTMR_SC_OVF 7
`define MTMR_SC_IRQEN 6
`define MTMR_SC_CLR 5
`define MTMR_SC_HALT 4

// timer_clock_config fields
`define MTMR_CK_SRC_HI 5
`define MTMR_CK_SRC_LO 4
`define MTMR_CK_PRE_HI 3
`define MTMR_CK_PRE_LO 0

// clock source codes
`define MTMR_SRC_BUS 2'h0
`define MTMR_SRC_FIXED 2'h1
`define MTMR_SRC_FALL 2'h2
`define MTMR_SRC_RISE 2'h3

// prescale code of the largest ratio
`define MTMR_PRE_MAX 4'h8

// reset values
`define MTMR_RST_SRC 2'h0
`define MTMR_RST_PRE 4'h0
`define MTMR_RST_COUNT 8'h00
`define MTMR_RST_LIMIT 8'h00
`define MTMR_RST_HALT 1'b1
`define MTMR_RST_IRQEN 1'b0

// count value at which a free-running counter wraps
`define MTMR_FREE_TOP 8'hff

// AXI responses
`define MTMR_RESP_OKAY 2'h0
`define MTMR_RESP_SLVERR 2'h2

`endif

// ### verification/mtmr_properties.sv
// Purpose: port-level properties of the modulo timer
// Assumes: bound to mtmr_top, one clock MCLK, async active-low RSTN
// Notes: read data is judged by the address taken on the AR channel
`timescale 1ns/1ps
`include "mtmr_defines.vh"
module mtmr_props (
    input wire MCLK,
    input wire RSTN,
    input wire IRQ,
    input wire [7:0] S_AXI_ARADDR,
    input wire S_AXI_ARVALID,
    input wire S_AXI_ARREADY,
    input wire [31:0] S_AXI_RDATA,
    input wire [1:0] S_AXI_RRESP,
    input wire S_AXI_RVALID,
    input wire S_AXI_RREADY,
    input wire S_AXI_AWVALID,
    input wire S_AXI_AWREADY,
    input wire [1:0] S_AXI_BRESP,
    input wire S_AXI_BVALID,
    input wire S_AXI_BREADY
);
    // =========================================================
    // helper: address of the read in flight
    reg [7:0] rd_addr_r;
    wire rd_st = S_AXI_RVALID && rd_addr_r == `MTMR_OFF_STATUS;
    wire rd_map = rd_addr_r[7:4] == 4'h0 && rd_addr_r[1:0] == 2'h0;
    // kept until the next AR is taken, so it still names the answer
    always @(posedge MCLK or negedge RSTN) begin
        if (!RSTN)
            rd_addr_r <= 8'h00;
        else if (S_AXI_ARVALID && S_AXI_ARREADY)
            rd_addr_r <= S_AXI_ARADDR;
    end
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RSTN);
    sequence ar_taken;
        S_AXI_ARVALID && S_AXI_ARREADY;
    endsequence
    sequence r_answer;
        ##[1:4] S_AXI_RVALID;
    endsequence
    // =========================================================
    // properties
    read_answer_a: assert property (ar_taken |-> r_answer)
        else $error("read answer missing");
    write_answer_a: assert property (S_AXI_AWVALID && S_AXI_AWREADY
        |-> ##[1:6] S_AXI_BVALID) else $error("write answer missing");
    bresp_stands_a: assert property (S_AXI_BVALID && !S_AXI_BREADY
        |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
        else $error("write response dropped");
    rdata_stands_a: assert property (S_AXI_RVALID && !S_AXI_RREADY
        |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
        else $error("read data dropped");
    upper_zero_a: assert property (S_AXI_RVALID |-> !(|S_AXI_RDATA[31:8]))
        else $error("upper read bits set");
    status_zero_a: assert property (rd_st |-> S_AXI_RDATA[5] == 1'b0
        && S_AXI_RDATA[3:0] == 4'h0) else $error("status spare bits set");
    cfg_zero_a: assert property (S_AXI_RVALID && rd_addr_r ==
        `MTMR_OFF_CLKCFG |-> S_AXI_RDATA[7:6] == 2'h0)
        else $error("config spare bits set");
    unmapped_read_a: assert property (S_AXI_RVALID && !rd_map |->
        S_AXI_RRESP == `MTMR_RESP_SLVERR && S_AXI_RDATA == 32'h0)
        else $error("unmapped read accepted");
    irq_masked_a: assert property (rd_st && !S_AXI_RDATA[6] |-> !IRQ)
        else $error("irq while disabled");
    irq_reset_a: assert property ($rose(RSTN) |-> !IRQ ##1 !IRQ)
        else $error("irq after reset");
endmodule
bind mtmr_top mtmr_props u_props (.MCLK(MCLK), .RSTN(RSTN), .IRQ(IRQ),
    .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID),
    .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
    .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID),
    .S_AXI_RREADY(S_AXI_RREADY), .S_AXI_AWVALID(S_AXI_AWVALID),
    .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_BRESP(S_AXI_BRESP),
    .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY));

// ### verification/mtmr_top_tb_top.sv
// Purpose: self-checking bench of the modulo timer over AXI4-Lite
// Assumes: count pin toggled by the bench, well under MCLK/4
// Notes: the pin and bus sources make every count exact; fixed is coarse
`timescale 1ns/1ps
`include "mtmr_defines.vh"
module mtmr_top_tb_top;
    reg mclk = 1'b0, rstn = 1'b0, fixed_clk = 1'b0, pin = 1'b0;
    reg [2:0] div = 3'h0;
    reg [7:0] awaddr = 8'h00, araddr = 8'h00;
    reg [31:0] wdata = 32'h0, rd_val = 32'h0, prev;
    reg awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    reg arvalid = 1'b0, rready = 1'b0;
    reg [1:0] rd_resp = 2'h0;
    wire irq, awready, wready, bvalid, arready, rvalid;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    integer errors = 0, checked = 0;
    // =========================================================
    // clocks: fixed-rate source has one period per eight bus cycles
    initial begin
        forever #2.5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        div <= div + 3'h1;
        fixed_clk <= div[2];
    end
    mtmr_top dut (.MCLK(mclk), .RSTN(rstn), .FIXED_RATE_CLOCK(fixed_clk),
        .EXTERNAL_COUNT_PIN(pin), .IRQ(irq), .S_AXI_AWADDR(awaddr),
        .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid),
        .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
        .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
        .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
        .S_AXI_RREADY(rready));
    // =========================================================
    // reporting
    task give_verdict;
        begin
            $display("comparisons %0d mismatches %0d", checked, errors);
            if (errors == 0 && checked > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask
    task chk(input string what, input [31:0] exp, input [31:0] got);
        begin
            checked = checked + 1;
            if (got !== exp) begin
                errors = errors + 1;
                $display("wrong value %s expected %h seen %h", what, exp, got);
            end
        end
    endtask
    // =========================================================
    // bus master: valid held until its own ready, answer ends the wait
    task wr(input [7:0] a, input [7:0] d);
        integer n;
        begin
            @(posedge mclk);
            awaddr <= a;
            wdata <= {24'h0, d};
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            bready <= 1'b1;
            for (n = 0; n >= 0; n = n + 1) begin
                @(posedge mclk);
                if (awready) awvalid <= 1'b0;
                if (wready) wvalid <= 1'b0;
                if (bvalid) n = -2;
                else if (n > 40) begin
                    errors = errors + 1;
                    $display("wrong value bvalid expected 1 seen 0");
                    give_verdict;
                end
            end
            bready <= 1'b0;
            chk("bresp", {30'h0, `MTMR_RESP_OKAY}, {30'h0, bresp});
        end
    endtask
    task rd(input [7:0] a);
        integer n;
        begin
            @(posedge mclk);
            araddr <= a;
            arvalid <= 1'b1;
            rready <= 1'b1;
            for (n = 0; n >= 0; n = n + 1) begin
                @(posedge mclk);
                if (arready) arvalid <= 1'b0;
                rd_val = rdata;
                rd_resp = rresp;
                if (rvalid) n = -2;
                else if (n > 40) begin
                    errors = errors + 1;
                    $display("wrong value rvalid expected 1 seen 0");
                    give_verdict;
                end
            end
            rready <= 1'b0;
        end
    endtask
    task rd_chk(input [7:0] a, input [7:0] exp);
        begin
            rd(a);
            chk($sformatf("reg %h", a), {24'h0, exp}, rd_val);
        end
    endtask
    // pin edges: each level held six cycles so the synchroniser sees it
    task pin_set(input v);
        begin
            @(posedge mclk);
            pin <= v;
            repeat (5) @(posedge mclk);
        end
    endtask
    task pulses(input integer k);
        integer i;
        begin
            for (i = 0; i < k; i = i + 1) begin
                pin_set(1'b1);
                pin_set(1'b0);
            end
        end
    endtask
    // =========================================================
    // scenarios
    task t_reset;
        begin
            rd_chk(`MTMR_OFF_STATUS, 8'h10);
            rd_chk(`MTMR_OFF_CLKCFG, 8'h00);
            rd_chk(`MTMR_OFF_COUNT, 8'h00);
            rd_chk(`MTMR_OFF_LIMIT, 8'h00);
            rd(8'h20);
            chk("rresp", {30'h0, `MTMR_RESP_SLVERR}, {30'h0, rd_resp});
        end
    endtask
    task t_modulo;
        begin
            wr(`MTMR_OFF_CLKCFG, 8'h30);
            wr(`MTMR_OFF_LIMIT, 8'h02);
            wr(`MTMR_OFF_STATUS, 8'h00);
            pulses(2);
            rd_chk(`MTMR_OFF_COUNT, 8'h02);
            rd_chk(`MTMR_OFF_STATUS, 8'h00);
            pulses(1);
            rd_chk(`MTMR_OFF_STATUS, 8'h80);
            wr(`MTMR_OFF_COUNT, 8'h55);
            rd_chk(`MTMR_OFF_COUNT, 8'h00);
        end
    endtask
    task t_flag;
        begin
            wr(`MTMR_OFF_STATUS, 8'h00);
            wr(`MTMR_OFF_STATUS, 8'h00);
            rd_chk(`MTMR_OFF_STATUS, 8'h00);
            pulses(3);
            wr(`MTMR_OFF_STATUS, 8'h00);
            rd_chk(`MTMR_OFF_STATUS, 8'h80);
            wr(`MTMR_OFF_STATUS, 8'h00);
            wr(`MTMR_OFF_STATUS, 8'h40);
            pulses(3);
            chk("irq", 32'h1, {31'h0, irq});
            rd(`MTMR_OFF_STATUS);
            pulses(3);
            wr(`MTMR_OFF_STATUS, 8'h40);
            rd_chk(`MTMR_OFF_STATUS, 8'hc0);
            pulses(1);
            wr(`MTMR_OFF_STATUS, 8'h60);
            rd_chk(`MTMR_OFF_COUNT, 8'h00);
            rd_chk(`MTMR_OFF_STATUS, 8'h40);
            chk("irq", 32'h0, {31'h0, irq});
            pulses(4);
            wr(`MTMR_OFF_LIMIT, 8'h05);
            rd_chk(`MTMR_OFF_COUNT, 8'h00);
            rd_chk(`MTMR_OFF_STATUS, 8'h40);
        end
    endtask
    task t_source;
        begin
            wr(`MTMR_OFF_STATUS, 8'h00);
            pulses(1);
            wr(`MTMR_OFF_CLKCFG, 8'h20);
            pin_set(1'b1);
            rd_chk(`MTMR_OFF_COUNT, 8'h01);
            pin_set(1'b0);
            wr(`MTMR_OFF_CLKCFG, 8'h21);
            pulses(2);
            rd_chk(`MTMR_OFF_COUNT, 8'h03);
            wr(`MTMR_OFF_STATUS, 8'h10);
            pulses(2);
            wr(`MTMR_OFF_STATUS, 8'h00);
            rd_chk(`MTMR_OFF_COUNT, 8'h03);
            wr(`MTMR_OFF_LIMIT, 8'h00);
            wr(`MTMR_OFF_CLKCFG, 8'h30);
            pulses(255);
            rd_chk(`MTMR_OFF_STATUS, 8'h00);
            pulses(1);
            rd_chk(`MTMR_OFF_STATUS, 8'h80);
            wr(`MTMR_OFF_CLKCFG, 8'h3f);
            pulses(256);
            rd_chk(`MTMR_OFF_COUNT, 8'h01);
            wr(`MTMR_OFF_CLKCFG, 8'h10);
            rd(`MTMR_OFF_COUNT);
            prev = rd_val;
            repeat (40) @(posedge mclk);
            rd(`MTMR_OFF_COUNT);
            checked = checked + 1;
            if (rd_val === prev) begin
                errors = errors + 1;
                $display("wrong value count expected change seen %h", rd_val);
            end
        end
    endtask
    // mid-run reset, then the bus clock source counts every cycle:
    // halt drops at the write's third edge, the read takes its word three
    // edges after the write ends, so three ticks have been counted
    task t_reset_again;
        begin
            wr(`MTMR_OFF_CLKCFG, 8'h3f);
            wr(`MTMR_OFF_LIMIT, 8'h05);
            @(posedge mclk);
            rstn <= 1'b0;
            repeat (2) @(posedge mclk);
            rstn <= 1'b1;
            chk("irq", 32'h0, {31'h0, irq});
            rd_chk(`MTMR_OFF_STATUS, 8'h10);
            rd_chk(`MTMR_OFF_CLKCFG, 8'h00);
            rd_chk(`MTMR_OFF_LIMIT, 8'h00);
            wr(`MTMR_OFF_STATUS, 8'h00);
            rd_chk(`MTMR_OFF_COUNT, 8'h03);
        end
    endtask
    // =========================================================
    // main sequence
    initial begin
        repeat (6) @(posedge mclk);
        rstn <= 1'b1;
        t_reset;
        t_modulo;
        t_flag;
        t_source;
        t_reset_again;
        give_verdict;
    end
endmodule
